// [rtl/emd_cfg.svh]
// timing and field constants for the memory access controller
// assumes a 250 MHz system clock
`ifndef EMD_CFG_SVH
`define EMD_CFG_SVH
`define EMD_CLK_PS        4000
`define EMD_T_ACC_NS      250
`define EMD_T_OE_NS       50
`define EMD_T_DF_NS       30
`define EMD_T_PGM_NS      100000
`define EMD_ACC_CYC  ((`EMD_T_ACC_NS*1000+`EMD_CLK_PS-1)/`EMD_CLK_PS)
`define EMD_OE_CYC   ((`EMD_T_OE_NS*1000+`EMD_CLK_PS-1)/`EMD_CLK_PS)
`define EMD_DF_CYC   ((`EMD_T_DF_NS*1000+`EMD_CLK_PS-1)/`EMD_CLK_PS)
`define EMD_PGM_CYC  ((`EMD_T_PGM_NS*1000+`EMD_CLK_PS-1)/`EMD_CLK_PS)
`define EMD_ADDR_W        16
`define EMD_CNT_W         16
`define EMD_ADDR_ZERO     16'h0000
`define EMD_ADDR_ONE      16'h0001
`define EMD_PAR_BIT       7
`define EMD_CNT_ZERO      16'h0000
`define EMD_CNT_ONE       16'h0001
`endif

// [rtl/emd_host.sv]
// host controller that drives a byte-wide UV memory through its pins
// assumes the pin level shifters turn the two voltage-request outputs
// into the elevated supplies; inputs are synchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
`include "emd_cfg.svh"
module emd_host (
  input  wire logic             clock_i,      // system clock
  input  wire logic             rst_b_i,      // async reset, active low
  input  wire logic             en_i,         // clock enable
  input  wire logic             req_valid_i,  // request strobe
  input  wire emd_pkg::emd_req_s req_i,       // request
  output var  logic             req_ready_o,  // idle, request taken
  output var  logic             rsp_valid_o,  // one-cycle answer
  output var  emd_pkg::emd_rsp_s rsp_o,       // answer
  output var  logic             sel_b_o,      // chip select, low active
  output var  logic             oe_b_o,       // output enable, low active
  output var  logic             vpp_on_o,     // supply on oe pin
  output var  logic             id_hv_o,      // id voltage on bit nine
  output var  logic [15:0]      addr_o,       // address lines
  input  wire logic [7:0]       data_lines_i, // data lines, in
  output var  logic [7:0]       data_lines_o, // data lines, out
  output var  logic [7:0]       data_oe_b_o   // data enable, low drives
);
  // ==========================================================
  // state machine
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_SETUP = 6'b000010,
    S_OE    = 6'b000100,
    S_PULSE = 6'b001000,
    S_FLOAT = 6'b010000,
    S_DONE  = 6'b100000
  } emd_state_e;

  emd_state_e                state;
  logic [`EMD_CNT_W-1:0]     cnt;
  emd_pkg::emd_req_s         cur;
  logic [7:0]                cap;
  logic                      go;
  logic                      hold_done;
  logic [`EMD_CNT_W-1:0]     setup_len;

  assign go        = en_i && req_valid_i && (state == S_IDLE);
  assign hold_done = (cnt <= `EMD_CNT_ONE);
  // address leads enable by access minus enable time
  assign setup_len = `EMD_CNT_W'(`EMD_ACC_CYC - `EMD_OE_CYC);

  // ==========================================================
  // counter reloads and request decode
  logic [`EMD_CNT_W-1:0]     oe_len;
  logic [`EMD_CNT_W-1:0]     pgm_len;
  logic [`EMD_CNT_W-1:0]     df_len;
  logic [`EMD_ADDR_W-1:0]    id_addr;
  logic                      is_id;
  logic                      is_prog;

  // reload values cut to the counter width on purpose
  assign oe_len  = `EMD_CNT_W'(`EMD_OE_CYC);
  assign pgm_len = `EMD_CNT_W'(`EMD_PGM_CYC);
  assign df_len  = `EMD_CNT_W'(`EMD_DF_CYC);
  // id readout only ever addresses byte 0 or byte 1
  assign id_addr = req_i.addr[0] ? `EMD_ADDR_ONE : `EMD_ADDR_ZERO;
  assign is_id   = (req_i.op == emd_pkg::EMD_OP_ID);
  // decoded from the captured request, valid after the take
  assign is_prog = (cur.op == emd_pkg::EMD_OP_PROG);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      cnt   <= `EMD_CNT_ZERO;
    end else if (en_i) begin
      unique case (state)
        S_IDLE: begin
          if (req_valid_i) begin
            state <= S_SETUP;
            cnt   <= setup_len;
          end
        end
        S_SETUP: begin
          if (hold_done) begin
            if (is_prog) begin
              state <= S_PULSE;
              cnt   <= pgm_len;
            end else begin
              state <= S_OE;
              cnt   <= oe_len;
            end
          end else begin
            cnt <= cnt - `EMD_CNT_ONE;
          end
        end
        S_PULSE: begin
          if (hold_done) begin
            state <= S_FLOAT;
            cnt   <= df_len;
          end else begin
            cnt <= cnt - `EMD_CNT_ONE;
          end
        end
        S_OE: begin
          if (hold_done) begin
            state <= S_FLOAT;
            cnt   <= df_len;
          end else begin
            cnt <= cnt - `EMD_CNT_ONE;
          end
        end
        S_FLOAT: begin
          // wait float time before bus is reused
          if (hold_done) begin
            state <= S_DONE;
          end else begin
            cnt <= cnt - `EMD_CNT_ONE;
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // request capture, id requests forced to address 0 or 1
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur <= '0;
    end else if (go) begin
      cur <= req_i;
      if (is_id) begin
        cur.addr <= id_addr;
      end
    end
  end

  // ==========================================================
  // pins
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_b_o      <= 1'b1;
      oe_b_o       <= 1'b1;
      vpp_on_o     <= 1'b0;
      id_hv_o      <= 1'b0;
      addr_o       <= `EMD_ADDR_ZERO;
      data_lines_o <= 8'h00;
      data_oe_b_o  <= 8'hFF;
    end else if (en_i) begin
      if (go) begin
        addr_o  <= is_id ?
                   id_addr :
                   req_i.addr;
        sel_b_o <= 1'b0;
        id_hv_o <= is_id;
        if (req_i.op == emd_pkg::EMD_OP_PROG) begin
          vpp_on_o     <= 1'b1;
          data_lines_o <= req_i.data;
          data_oe_b_o  <= 8'h00;
        end
      end
      // enable falls only once the address has settled
      if (state == S_SETUP && hold_done &&
          !is_prog) begin
        oe_b_o <= 1'b0;
      end
      if ((state == S_OE || state == S_PULSE) && hold_done) begin
        oe_b_o       <= 1'b1;
        vpp_on_o     <= 1'b0;
        sel_b_o      <= 1'b1;
        data_oe_b_o  <= 8'hFF;
      end
      if (state == S_FLOAT && hold_done) begin
        id_hv_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // answer
  // odd parity: reduction xor is one for an odd count of ones
  logic par_odd;
  assign par_odd = ^cap;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap <= 8'h00;
    end else if (en_i && state == S_OE && hold_done) begin
      cap <= data_lines_i;
    end else if (en_i && state == S_PULSE && hold_done) begin
      // writes report the byte driven, no stale read leaks out
      cap <= cur.data;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
      req_ready_o <= 1'b0;
    end else if (en_i) begin
      rsp_valid_o <= (state == S_DONE);
      req_ready_o <= (state == S_IDLE) && !req_valid_i ||
                     (state == S_DONE);
      if (state == S_DONE) begin
        rsp_o.data   <= cap;
        rsp_o.par_ok <= par_odd;
        rsp_o.match  <= (cap == cur.data);
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/emd_pkg.sv]
// types of the memory access controller
// assumes emd_cfg.svh is on the include path
`default_nettype none
package emd_pkg;
  typedef enum logic [1:0] {
    EMD_OP_READ   = 2'h0,
    EMD_OP_PROG   = 2'h1,
    EMD_OP_ID     = 2'h2,
    EMD_OP_VERIFY = 2'h3
  } emd_op_e;

  typedef struct packed {
    emd_op_e     op;
    logic [15:0] addr;
    logic [7:0]  data;
  } emd_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic       par_ok;
    logic       match;
  } emd_rsp_s;
endpackage
`default_nettype wire

// [verif/emd_host_props.sv]
// pin-level checker for the memory access controller
// assumes it is bound to emd_host and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module emd_host_props (
  input wire logic              clock_i,
  input wire logic              rst_b_i,
  input wire logic              en_i,
  input wire logic              req_valid_i,
  input wire emd_pkg::emd_req_s req_i,
  input wire logic              req_ready_o,
  input wire logic              rsp_valid_o,
  input wire emd_pkg::emd_rsp_s rsp_o,
  input wire logic              sel_b_o,
  input wire logic              oe_b_o,
  input wire logic              vpp_on_o,
  input wire logic              id_hv_o,
  input wire logic [15:0]       addr_o,
  input wire logic [7:0]        data_oe_b_o
);
  // ====================
  // assertions
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire take = req_valid_i && req_ready_o && en_i;
  id_addr_a: assert property (id_hv_o |-> addr_o[15:1] == 15'h0)
    else $error("id address not held low");
  id_mode_a: assert property (id_hv_o |-> !vpp_on_o)
    else $error("id voltage with supply on");
  read_pins_a: assert property (!oe_b_o |-> !sel_b_o && !vpp_on_o
    && data_oe_b_o == 8'hff) else $error("read pins wrong");
  prog_pins_a: assert property (vpp_on_o |-> !sel_b_o && oe_b_o
    && data_oe_b_o == 8'h00) else $error("program pins wrong");
  addr_hold_a: assert property ($fell(oe_b_o) |->
    addr_o == $past(addr_o, 50) && $past(sel_b_o, 50) == 1'b0)
    else $error("address setup too short");
  rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer longer than one cycle");
  rsp_parity_a: assert property (rsp_valid_o |->
    rsp_o.par_ok == ^rsp_o.data) else $error("parity flag wrong");
  take_sel_a: assert property (take |=> !sel_b_o && !req_ready_o)
    else $error("select not driven on take");
  read_time_a: assert property (take && req_i.op !=
    emd_pkg::EMD_OP_PROG |-> ##[60:100] rsp_valid_o)
    else $error("read answer late");
  idle_pins_a: assert property (req_ready_o |-> sel_b_o && oe_b_o
    && !vpp_on_o && !id_hv_o) else $error("idle pins not standby");
  prog_c: cover property (vpp_on_o);
  id_c: cover property (id_hv_o && addr_o[0]);
  match_c: cover property (rsp_valid_o && rsp_o.match);
  stall_c: cover property (!en_i && !sel_b_o);
endmodule
bind emd_host emd_host_props emd_host_props_inst (.*);
`default_nettype wire

// [verif/emd_mem_model.sv]
// behavioural byte-wide memory facing the controller pins
// assumes level controls from emd_host and a resolved data bus
`timescale 1ns/1ps
`default_nettype none
module emd_mem_model #(
  parameter logic [7:0] MAKER  = 8'h2a, // arbitrary value
  parameter logic [7:0] DEVICE = 8'h4c  // arbitrary value
) (
  input  wire logic        clock_i, // clock
  input  wire logic        sel_b_i, // select, low active
  input  wire logic        oe_b_i,  // enable, low active
  input  wire logic        vpp_i,   // supply on enable pin
  input  wire logic        id_hv_i, // id voltage on bit nine
  input  wire logic [15:0] addr_i,  // address
  input  wire logic [7:0]  din_i,   // resolved bus
  output var  logic [7:0]  dq_o     // memory drive
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic       drv;
  logic [7:0] val;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  assign drv = !sel_b_i && !oe_b_i && !vpp_i;
  assign val = !id_hv_i ? mem[addr_i[7:0]]
    : addr_i[0] ? DEVICE : MAKER;
  // floating bus shows the inverse of the last byte
  assign dq_o = drv ? val : ~last;
  always @(posedge clock_i) begin
    if (drv) last <= val;
    if (vpp_i && !sel_b_i) mem[addr_i[7:0]] <=
      mem[addr_i[7:0]] & din_i;
  end
endmodule
`default_nettype wire

// [verif/tb_emd_host.sv]
// self-checking bench for the memory access controller
// assumes emd_host, the memory model and the checker are compiled
`timescale 1ns/1ps
`default_nettype none
module tb_emd_host;
  // ====================
  // pins and bookkeeping
  localparam logic [7:0] MAKER = 8'h2a;  // arbitrary value
  localparam logic [7:0] DEVICE = 8'h4c; // arbitrary value
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic en_i = 1'b1;
  emd_pkg::emd_req_s req_i = '0;
  logic req_ready_o, rsp_valid_o, sel_b_o, oe_b_o, vpp_on_o, id_hv_o;
  emd_pkg::emd_rsp_s rsp_o;
  logic [15:0] addr_o;
  logic [7:0] data_lines_o, data_oe_b_o, dq, bus;
  int num_errors = 0;
  int total_checks = 0;
  integer seed = 32'hf678;
  emd_pkg::emd_rsp_s exp_q [$];
  assign bus = (data_lines_o & ~data_oe_b_o) | (dq & data_oe_b_o);
  initial forever #2 clock_i = ~clock_i;
  emd_host emd_host_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .en_i(en_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_o(rsp_o), .sel_b_o(sel_b_o), .oe_b_o(oe_b_o),
    .vpp_on_o(vpp_on_o), .id_hv_o(id_hv_o), .addr_o(addr_o),
    .data_lines_i(bus), .data_lines_o(data_lines_o),
    .data_oe_b_o(data_oe_b_o));
  emd_mem_model #(.MAKER(MAKER), .DEVICE(DEVICE)) emd_mem_model_inst (
    .clock_i(clock_i), .sel_b_i(sel_b_o), .oe_b_i(oe_b_o),
    .vpp_i(vpp_on_o), .id_hv_i(id_hv_o), .addr_i(addr_o),
    .din_i(bus), .dq_o(dq));
  // ====================
  // tasks
  task automatic summarize();
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("unexpected pending: expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(emd_pkg::emd_rsp_s e, emd_pkg::emd_rsp_s g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected answer: expected %h seen %h", e, g);
    end
  endtask
  task automatic op(emd_pkg::emd_op_e o, logic [15:0] a,
                    logic [7:0] d, logic [7:0] e, int s = 0);
    for (int i = 0; i < 99 && req_ready_o !== 1'b1; i++)
      @(posedge clock_i) #1;
    if (req_ready_o !== 1'b1) begin
      num_errors++;
      $display("unexpected ready: expected 1 seen %b", req_ready_o);
    end
    exp_q.push_back('{data: e, par_ok: ^e, match: e == d});
    req_i = '{op: o, addr: a, data: d};
    req_valid_i = 1'b1;
    @(posedge clock_i) #1;
    req_valid_i = 1'b0;
    if (s > 0) begin
      repeat (8) @(posedge clock_i) #1;
      en_i = 1'b0;
      repeat (s) @(posedge clock_i) #1;
      en_i = 1'b1;
    end
    for (int i = 0; i < 30000 && rsp_valid_o !== 1'b1; i++)
      @(posedge clock_i) #1;
    if (rsp_valid_o !== 1'b1) begin
      num_errors++;
      $display("unexpected answer: expected valid seen %b", rsp_valid_o);
    end
    @(posedge clock_i) #1;
  endtask
  // ====================
  // result watcher, sequence, watchdog
  always @(negedge clock_i) begin
    if (rsp_valid_o === 1'b1 && exp_q.size() != 0) begin
      chk(exp_q.pop_front(), rsp_o);
    end else if (rsp_valid_o === 1'b1) begin
      num_errors++;
      $display("unexpected answer: expected none seen %h", rsp_o);
    end
  end
  initial begin
    logic [15:0] a;
    logic [7:0] d;
    repeat (3) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = 16'($random(seed));
      op(emd_pkg::EMD_OP_READ, a, 8'h00, a[7:0] ^ 8'h5a,
         (i == 5) ? 16 : 0);
    end
    $display("read test done");
    op(emd_pkg::EMD_OP_ID, a & 16'hfffe, 8'h00, MAKER);
    op(emd_pkg::EMD_OP_ID, a | 16'h0001, 8'h00, DEVICE);
    $display("id test done");
    d = 8'($random(seed));
    op(emd_pkg::EMD_OP_PROG, a, d, d);
    op(emd_pkg::EMD_OP_VERIFY, a, d, (a[7:0] ^ 8'h5a) & d);
    op(emd_pkg::EMD_OP_VERIFY, a, ~d, (a[7:0] ^ 8'h5a) & d);
    op(emd_pkg::EMD_OP_READ, a, 8'h00, (a[7:0] ^ 8'h5a) & d);
    $display("program test done");
    summarize();
  end
  initial begin
    #(4 * 60000);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
